// >>> bench/fac_ctrl_sva.sv
// Purpose: port checks for the flash access and unlock control block
// Assumes: classic wishbone master holds a request until answered
// Notes: bound onto every fac_ctrl instance
`timescale 1ns/1ns
`include "fac_params.svh"
module fac_ctrl_chk
   import fac_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic busy_o,
   input wire logic reload_o,
   input wire fac_pkg::fac_key_t key_state_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   logic req; // request not yet answered
   logic kw; // key register write
   logic arr; // array window access
   logic crw; // control register write
   logic bad; // key write that must be refused
   assign req = cyc_i && stb_i && !ack_o && !err_o;
   assign kw = req && we_i && adr_i == 32'h4002_2008;
   assign arr = adr_i[31:16] == 16'h0800 || adr_i[31:12] == 20'h1_fff0;
   assign crw = cyc_i && stb_i && we_i && adr_i == 32'h4002_2014;
   assign bad = kw && (key_state_o == FAC_DEAD || (key_state_o == FAC_LOCKED && dat_i != `FAC_FIRST_UNLOCK_VALUE)
                || (key_state_o == FAC_HALF && dat_i != `FAC_SECOND_UNLOCK_VALUE));
   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
   chk_ans_excl: assert property (!(ack_o && err_o)) else $error("ack and err together");
   chk_ans_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
      else $error("answer without request");
   chk_reset_lock: assert property ($past(rst_i) |-> key_state_o == FAC_LOCKED)
      else $error("not locked after reset");
   chk_good_first: assert property (kw && key_state_o == FAC_LOCKED && dat_i == `FAC_FIRST_UNLOCK_VALUE
      |=> ack_o && key_state_o == FAC_HALF) else $error("first key not taken");
   chk_open_order: assert property (key_state_o == FAC_OPEN && $past(key_state_o) != FAC_OPEN
      |-> $past(key_state_o) == FAC_HALF) else $error("opened out of order");
   chk_bad_key: assert property (bad |=> err_o && key_state_o == FAC_DEAD)
      else $error("wrong key not refused");
   chk_dead_stays: assert property (key_state_o == FAC_DEAD |=> key_state_o == FAC_DEAD)
      else $error("dead lock left");
   chk_read_stall: assert property (busy_o && cyc_i && stb_i && !we_i && arr |-> !ack_o)
      else $error("read answered while busy");
   chk_ctrl_stall: assert property (busy_o && crw |-> !ack_o) else $error("control write while busy");
   chk_reload_src: assert property (reload_o |-> $past(cyc_i && stb_i && we_i && dat_i[27]))
      else $error("reload without write");
   cov_open: cover property (key_state_o == FAC_OPEN);
   cov_stall: cover property (busy_o && cyc_i && stb_i && !we_i);
   cov_err: cover property (err_o);
   cov_reload: cover property (reload_o);
endmodule : fac_ctrl_chk

bind fac_ctrl fac_ctrl_chk u_fac_ctrl_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .busy_o(busy_o),
   .reload_o(reload_o), .key_state_o(key_state_o));

// >>> bench/fac_master.sv
// Purpose: classic wishbone master in place of the processor
// Assumes: one transfer at a time
// Notes: released address and data lines carry inverted values, not stale ones
`timescale 1ns/1ns
module fac_master (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic err_i,
   input wire logic [31:0] rdat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [31:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   // idle bus from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 32'h0000_0000;
      sel_o = 4'hf;
      dat_o = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one cycle, held until ack or err; n counts edges waited
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, output int n);
      n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && err_i !== 1'b1);
      r = rdat_i;
      e = err_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
      @(posedge clk_i);
   endtask : xfer
endmodule : fac_master

// >>> bench/testbench.sv
// Purpose: self-checking bench of the flash access and unlock control
// Assumes: short operation count of 8 cycles
// Notes: array words are written before they are compared
`timescale 1ns/1ns
module testbench;
   import fac_pkg::*;
   localparam int OPC = 8;
   localparam logic [31:0] R_ACR = 32'h4002_2000;
   localparam logic [31:0] R_KEY = 32'h4002_2008;
   localparam logic [31:0] R_SR = 32'h4002_2010;
   localparam logic [31:0] R_CR = 32'h4002_2014;
   localparam logic [31:0] R_WRP = 32'h4002_2018;
   localparam logic [31:0] K1 = 32'h4567_0123;
   localparam logic [31:0] K2 = 32'hcdef_89ab;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, err, busy, reload, berr;
   logic [31:0] adr, wdat, rdat, rdata;
   logic [3:0] sel;
   fac_key_t key_state;
   int lat, n_errors = 0, checks = 0, cycles = 0, n_reload = 0, n_busy = 0;
   always #5 clk_i = ~clk_i;
   fac_ctrl #(.OP_CYCLES(OPC)) u_fac_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
      .busy_o(busy), .reload_o(reload), .key_state_o(key_state));
   fac_master u_fac_master (.clk_i(clk_i), .ack_i(ack), .err_i(err), .rdat_i(rdat), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // pulse counters and hang limit
   always @(posedge clk_i) begin
      cycles++;
      if (reload === 1'b1) n_reload++;
      if (busy === 1'b1) n_busy++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_key(input fac_key_t got, input fac_key_t exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: key state %0d expected %0d", $time, got, exp);
      end
   endtask : cmp_key
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      u_fac_master.xfer(w, a, d, rdata, berr, lat);
   endtask : bus
   // read, expect a normal answer and a value
   task automatic rd_cmp(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      cmp_val({31'h0, berr}, 32'h0);
      cmp_val(rdata, exp);
   endtask : rd_cmp
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   task automatic unlock();
      bus(1'b1, R_KEY, K1);
      cmp_key(key_state, FAC_HALF);
      bus(1'b1, R_KEY, K2);
      cmp_key(key_state, FAC_OPEN);
   endtask : unlock
   ////////////////////////////////////////////////////////////////////////////////
   // locked state, key reads zero, only reload acts while locked
   task automatic t_locked();
      int n0;
      cmp_key(key_state, FAC_LOCKED);
      rd_cmp(R_KEY, 32'h0000_0000);
      n0 = n_reload;
      bus(1'b1, R_CR, 32'h0800_0003);
      cmp_val(32'(n_reload - n0), 32'h1);
      rd_cmp(R_CR, 32'h8000_0000);
   endtask : t_locked
   // stalls, program, latency; fast oscillator taken as running
   task automatic t_flash();
      int n0;
      n0 = n_busy;
      bus(1'b1, R_CR, 32'h0000_0002);
      bus(1'b1, 32'h0800_0080, 32'h0000_0000);
      rd_cmp(32'h0800_0084, 32'hffff_ffff);
      cmp_val({31'h0, lat > 3}, 32'h1);
      cmp_val({31'h0, n_busy > n0}, 32'h1);
      bus(1'b1, R_CR, 32'h0000_0001);
      bus(1'b1, 32'h0800_0084, 32'h1234_5678);
      bus(1'b1, R_CR, 32'h0000_0001);
      cmp_val({31'h0, lat > 2}, 32'h1);
      rd_cmp(32'h0800_0084, 32'h1234_5678);
      cmp_val(32'(lat), 32'h3);
      bus(1'b1, R_ACR, 32'h0000_0001);
      rd_cmp(32'h0800_0084, 32'h1234_5678);
      cmp_val(32'(lat), 32'h4);
      bus(1'b1, R_ACR, 32'h0000_0000);
   endtask : t_flash
   // loader page erase allowed, id page program, sector erase refused
   task automatic t_loader();
      bus(1'b1, R_CR, 32'h0000_0002);
      bus(1'b1, 32'h1fff_0000, 32'h0000_0000);
      bus(1'b1, R_CR, 32'h0000_0001);
      bus(1'b1, 32'h1fff_0e04, 32'h0000_0000);
      rd_cmp(32'h1fff_0e04, 32'h0000_0000);
      bus(1'b1, R_CR, 32'h0000_0008);
      bus(1'b1, 32'h1fff_0000, 32'h0000_0000);
      rd_cmp(R_SR, 32'h0000_0011);
      bus(1'b1, R_SR, 32'h0000_0011);
      rd_cmp(32'h1fff_0004, 32'hffff_ffff);
   endtask : t_loader
   // protected mass erase, sector map, mass erase spares info area
   task automatic t_mass();
      bus(1'b1, R_WRP, 32'h0000_0001);
      bus(1'b1, R_CR, 32'h0000_0004);
      bus(1'b1, 32'h0800_0000, 32'h0000_0000);
      rd_cmp(R_SR, 32'h0000_0010);
      rd_cmp(32'h0800_0084, 32'h1234_5678);
      bus(1'b1, R_SR, 32'h0000_0011);
      bus(1'b1, R_WRP, 32'h0000_0000);
      bus(1'b1, R_CR, 32'h0000_0008);
      bus(1'b1, 32'h0800_0f00, 32'h0000_0000);
      rd_cmp(32'h0800_0084, 32'hffff_ffff);
      bus(1'b1, R_CR, 32'h0000_0001);
      bus(1'b1, 32'h0800_0084, 32'h1234_5678);
      bus(1'b1, R_CR, 32'h0000_0004);
      bus(1'b1, 32'h0800_0000, 32'h0000_0000);
      rd_cmp(32'h0800_0084, 32'hffff_ffff);
      rd_cmp(32'h1fff_0e04, 32'h0000_0000);
   endtask : t_mass
   // relock; key writes when open, wrong keys, unmapped
   task automatic t_keys();
      bus(1'b1, R_CR, 32'h8000_0000);
      cmp_key(key_state, FAC_LOCKED);
      bus(1'b1, R_CR, 32'h0000_0001);
      rd_cmp(R_CR, 32'h8000_0000);
      unlock();
      bus(1'b1, R_KEY, K1);
      cmp_val({31'h0, berr}, 32'h1);
      bus(1'b0, 32'h4002_2020, 32'h0000_0000);
      cmp_val({31'h0, berr}, 32'h1);
      do_reset();
      bus(1'b1, R_KEY, 32'h0000_0000);
      cmp_val({31'h0, berr}, 32'h1);
      bus(1'b1, R_KEY, K1);
      cmp_val({31'h0, berr}, 32'h1);
      cmp_key(key_state, FAC_DEAD);
      do_reset();
      bus(1'b1, R_KEY, K1);
      cmp_val({31'h0, berr}, 32'h0);
      bus(1'b1, R_KEY, 32'hcdef_89aa);
      cmp_val({31'h0, berr}, 32'h1);
      cmp_key(key_state, FAC_DEAD);
   endtask : t_keys
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      t_locked();
      unlock();
      t_flash();
      t_loader();
      t_mass();
      t_keys();
      give_verdict();
   end
endmodule : testbench

// >>> design/fac_array.sv
// Purpose: flash storage array, main and information areas
// Assumes: word index per area, erase by range
// Notes: one read port, one program port, erase clears to ones
`timescale 1ns/1ns
module fac_array #(
   parameter int MAIN_WORDS = 16384,
   parameter int INFO_WORDS = 1024
) (
   input wire logic clk_i,
   input wire logic rd_info_i,
   input wire logic [13:0] rd_idx_i,
   output logic [31:0] rd_data_o,
   input wire logic wr_en_i,
   input wire logic wr_info_i,
   input wire logic [13:0] wr_idx_i,
   input wire logic [31:0] wr_data_i,
   input wire logic er_en_i,
   input wire logic er_info_i,
   input wire logic [13:0] er_lo_i,
   input wire logic [13:0] er_hi_i
);
   initial begin
      if (MAIN_WORDS != 16384 || INFO_WORDS != 1024) begin
         $error("array geometry not supported");
      end
   end
   // storage words
   logic [31:0] main_mem [MAIN_WORDS];
   logic [31:0] info_mem [INFO_WORDS];

   ////////////////////////////////////////////////////////////////////////
   // registered read
   always_ff @(posedge clk_i) begin
      if (rd_info_i) begin
         rd_data_o <= info_mem[rd_idx_i[9:0]];
      end else begin
         rd_data_o <= main_mem[rd_idx_i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // program ands bits, erase sets a range to ones
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         if (wr_info_i) begin
            info_mem[wr_idx_i[9:0]] <= info_mem[wr_idx_i[9:0]] & wr_data_i;
         end else begin
            main_mem[wr_idx_i] <= main_mem[wr_idx_i] & wr_data_i;
         end
      end else if (er_en_i) begin
         for (int i = 0; i < MAIN_WORDS; i++) begin
            if (!er_info_i && i >= int'(er_lo_i) && i <= int'(er_hi_i)) begin
               main_mem[i] <= 32'hFFFF_FFFF;
            end
         end
         for (int j = 0; j < INFO_WORDS; j++) begin
            if (er_info_i && j >= int'(er_lo_i) && j <= int'(er_hi_i)) begin
               info_mem[j] <= 32'hFFFF_FFFF;
            end
         end
      end
   end
endmodule : fac_array

// >>> design/fac_ctrl.sv
// Purpose: flash read path, erase and program control, unlock keys
// Assumes: classic wishbone for both array reads and registers
// Notes: one bus port serves array window and register window
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "fac_params.svh"

// What this block does
// - main area 64 kbytes of 32-bit words
// - information area 4 kbytes, 1k words
// - page 128 bytes, sector 4 kbytes
// - main base, sixteen sectors of 32 pages
// - information pages: loader, id, option, factory
// - page erase main and loader pages, no loader sector
// - mass erase refused under write protection
// - mass erase never touches loader area
// - fetches and reads are plain bus reads
// - latency setting adds exactly one wait
// - reads stall during operation, then complete
// - control locked after reset except reload
// - two exact key writes unlock
// - wrong key locks until reset
// - wrong key answers with bus error
// - lock bit write relocks control
// - control writes stall while busy
// - busy set at operation start
module fac_ctrl #(
   parameter int OP_CYCLES = (`FAC_OP_NS + `FAC_CLK_NS - 1) / `FAC_CLK_NS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   output logic busy_o,
   output logic reload_o,
   output fac_pkg::fac_key_t key_state_o
);
   import fac_pkg::*;

   initial begin
      if (OP_CYCLES < 1) begin
         $error("operation length must be at least one cycle");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode
   logic req; // new request, no answer pending
   logic in_main; // address in main area
   logic in_info; // address in information area
   logic in_regs; // address in register window
   logic [4:0] reg_ofs; // register byte offset
   logic [4:0] info_page; // page within information area
   logic [13:0] word_idx; // word within area
   logic [31:0] main_ofs; // byte offset from main base
   logic [31:0] info_ofs; // byte offset from info base

   assign main_ofs = adr_i - `FAC_MAIN_BASE;
   assign info_ofs = adr_i - `FAC_INFO_BASE;
   assign in_main = (adr_i >= `FAC_MAIN_BASE) && (main_ofs < `FAC_MAIN_BYTES);
   assign in_info = (adr_i >= `FAC_INFO_BASE) && (info_ofs < `FAC_INFO_BYTES);
   assign in_regs = (adr_i & `FAC_REG_MASK) == `FAC_REG_BASE;
   assign reg_ofs = adr_i[4:0];
   assign info_page = info_ofs[11:7];
   assign word_idx = in_info ? {4'h0, info_ofs[11:2]} : main_ofs[15:2];
   assign req = cyc_i && stb_i && !ack_o && !err_o;

   ////////////////////////////////////////////////////////////////////////
   // state
   fac_key_t key_state; // unlock sequencer
   logic [31:0] ctrl; // control register
   logic [31:0] acr; // access control, bit 0 is latency
   logic [31:0] wrp; // write protection mask per sector
   logic busy; // operation running
   logic eop; // end of operation, sticky
   logic wrperr; // protection error, sticky
   logic wait_done; // latency wait state served
   logic rd_pend; // array read issued, data next cycle
   logic op_go; // start pulse for timer
   logic op_done; // timer finished
   fac_op_t op_kind; // running operation
   logic op_info; // operation targets information area
   logic [13:0] op_lo; // first word of range
   logic [13:0] op_hi; // last word of range
   logic [13:0] op_idx; // program word
   logic [31:0] op_data; // program data
   logic [31:0] arr_rd; // array read data
   logic arr_info_rd; // read selects information area
   logic ctrl_locked; // control writes masked

   assign ctrl_locked = key_state != FAC_OPEN;

   fac_timer #(.CYCLES(OP_CYCLES)) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(op_go),
      .done_o(op_done)
   );

   fac_array u_array (
      .clk_i(clk_i),
      .rd_info_i(arr_info_rd),
      .rd_idx_i(word_idx),
      .rd_data_o(arr_rd),
      .wr_en_i(op_done && op_kind == FAC_OP_PROG),
      .wr_info_i(op_info),
      .wr_idx_i(op_idx),
      .wr_data_i(op_data),
      .er_en_i(op_done && op_kind != FAC_OP_PROG && op_kind != FAC_OP_NONE),
      .er_info_i(op_info),
      .er_lo_i(op_lo),
      .er_hi_i(op_hi)
   );
   assign arr_info_rd = in_info;

   ////////////////////////////////////////////////////////////////////////
   // classify a write into the array as an operation
   fac_op_t next_op; // kind the write would start
   logic next_refuse; // protection refuses it
   logic [13:0] next_lo; // range start
   logic [13:0] next_hi; // range end
   logic sec_prot; // target sector protected

   assign sec_prot = wrp[main_ofs[15:12]];

   always_comb begin
      next_op = FAC_OP_NONE;
      next_refuse = 1'b0;
      next_lo = word_idx;
      next_hi = word_idx;
      if (ctrl[`FAC_CR_PG]) begin
         next_op = FAC_OP_PROG;
         next_refuse = in_main ? sec_prot : (info_page <= `FAC_LOADER_LAST_PAGE);
      end else if (ctrl[`FAC_CR_PER]) begin
         // page erase in main and loader pages
         next_op = FAC_OP_PAGE;
         next_lo = {word_idx[13:5], 5'h00};
         next_hi = {word_idx[13:5], 5'h1F};
         next_refuse = in_main ? sec_prot : (info_page > `FAC_LOADER_LAST_PAGE);
      end else if (ctrl[`FAC_CR_SER]) begin
         next_op = FAC_OP_SECTOR;
         next_lo = {word_idx[13:10], 10'h000};
         next_hi = {word_idx[13:10], 10'h3FF};
         next_refuse = in_info || sec_prot;
      end else if (ctrl[`FAC_CR_MER]) begin
         next_op = FAC_OP_MASS;
         next_lo = 14'h0000;
         next_hi = 14'h3FFF;
         next_refuse = in_info || (wrp != 32'h0000_0000);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer: ack, err, read data; stalls by withholding ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         wait_done <= 1'b0;
         rd_pend <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         if (rd_pend) begin
            // array data valid now
            rd_pend <= 1'b0;
            wait_done <= 1'b0;
            ack_o <= 1'b1;
            dat_o <= arr_rd;
         end else if (req) begin
            if ((in_main || in_info) && !we_i) begin
               // reads wait out any operation
               if (!busy) begin
                  if (acr[0] && !wait_done) begin
                     wait_done <= 1'b1;
                  end else begin
                     rd_pend <= 1'b1;
                  end
               end
            end else if ((in_main || in_info) && we_i) begin
               if (!busy) begin
                  ack_o <= 1'b1;
               end
            end else if (in_regs) begin
               if (we_i && reg_ofs == `FAC_OFS_CR && busy) begin
                  ack_o <= 1'b0;
               end else if (we_i && reg_ofs == `FAC_OFS_KEY
                            && key_state == FAC_LOCKED && dat_i != `FAC_FIRST_UNLOCK_VALUE) begin
                  err_o <= 1'b1;
               end else if (we_i && reg_ofs == `FAC_OFS_KEY
                            && key_state == FAC_HALF && dat_i != `FAC_SECOND_UNLOCK_VALUE) begin
                  err_o <= 1'b1;
               end else if (we_i && reg_ofs == `FAC_OFS_KEY
                            && (key_state == FAC_OPEN || key_state == FAC_DEAD)) begin
                  err_o <= 1'b1;
               end else begin
                  ack_o <= 1'b1;
                  unique case (reg_ofs)
                     `FAC_OFS_ACR: dat_o <= acr;
                     `FAC_OFS_KEY: dat_o <= 32'h0000_0000;
                     `FAC_OFS_SR: dat_o <= {15'h0000, busy, 11'h000, wrperr, 3'h0, eop};
                     `FAC_OFS_CR: dat_o <= ctrl;
                     `FAC_OFS_WRP: dat_o <= wrp;
                     default: dat_o <= 32'h0000_0000;
                  endcase
               end
            end else begin
               err_o <= 1'b1; // unmapped address
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unlock sequencer
   logic key_wr; // any write to key register, accepted or refused
   assign key_wr = req && we_i && in_regs && reg_ofs == `FAC_OFS_KEY;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_state <= FAC_LOCKED;
      end else if (key_wr) begin
         unique case (key_state)
            FAC_LOCKED: key_state <= (dat_i == `FAC_FIRST_UNLOCK_VALUE) ? FAC_HALF : FAC_DEAD;
            FAC_HALF: key_state <= (dat_i == `FAC_SECOND_UNLOCK_VALUE) ? FAC_OPEN : FAC_DEAD;
            FAC_OPEN: key_state <= FAC_DEAD;
            FAC_DEAD: key_state <= FAC_DEAD;
         endcase
      end else if (req && we_i && in_regs && reg_ofs == `FAC_OFS_CR && !busy
                   && !ctrl_locked && dat_i[`FAC_CR_LOCK]) begin
         key_state <= FAC_LOCKED;
      end
   end
   assign key_state_o = key_state;

   ////////////////////////////////////////////////////////////////////////
   // control, access and protection registers
   logic cr_wr; // control write accepted this cycle
   assign cr_wr = req && we_i && in_regs && reg_ofs == `FAC_OFS_CR && !busy;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `FAC_CR_RESET;
         acr <= `FAC_ACR_RESET;
         wrp <= 32'h0000_0000;
         reload_o <= 1'b0;
      end else begin
         reload_o <= 1'b0;
         if (cr_wr) begin
            if (ctrl_locked) begin
               reload_o <= dat_i[`FAC_CR_RELOAD];
            end else begin
               ctrl <= {dat_i[31:1] & 31'h0000_000F >> 1, dat_i[0]} | (dat_i[`FAC_CR_LOCK] ? `FAC_CR_RESET : 32'h0);
               reload_o <= dat_i[`FAC_CR_RELOAD];
            end
         end else begin
            ctrl[`FAC_CR_LOCK] <= ctrl_locked;
         end
         if (req && we_i && in_regs && reg_ofs == `FAC_OFS_ACR) begin
            acr <= {31'h0000_0000, dat_i[0]};
         end
         if (req && we_i && in_regs && reg_ofs == `FAC_OFS_WRP && !ctrl_locked) begin
            wrp <= {16'h0000, dat_i[15:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operation start, busy and status flags
   logic arr_wr; // array write accepted this cycle
   assign arr_wr = req && we_i && (in_main || in_info) && !busy;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         eop <= 1'b0;
         wrperr <= 1'b0;
         op_go <= 1'b0;
         op_kind <= FAC_OP_NONE;
         op_info <= 1'b0;
         op_lo <= 14'h0000;
         op_hi <= 14'h0000;
         op_idx <= 14'h0000;
         op_data <= 32'h0000_0000;
      end else begin
         op_go <= 1'b0;
         // status writes clear by writing one; a setting event wins
         if (req && we_i && in_regs && reg_ofs == `FAC_OFS_SR) begin
            if (dat_i[`FAC_SR_EOP]) eop <= 1'b0;
            if (dat_i[`FAC_SR_WRPERR]) wrperr <= 1'b0;
         end
         if (arr_wr && !ctrl_locked && next_op != FAC_OP_NONE) begin
            if (next_refuse) begin
               wrperr <= 1'b1;
            end else begin
               busy <= 1'b1;
               op_go <= 1'b1;
               op_kind <= next_op;
               op_info <= in_info;
               op_lo <= next_lo;
               op_hi <= next_hi;
               op_idx <= word_idx;
               op_data <= dat_i;
            end
         end
         if (op_done) begin
            busy <= 1'b0;
            eop <= 1'b1;
            op_kind <= FAC_OP_NONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // busy output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= busy || op_go;
      end
   end
endmodule : fac_ctrl

// >>> design/fac_timer.sv
// Purpose: operation duration counter
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the count runs out
`timescale 1ns/1ns
module fac_timer #(
   parameter int CYCLES = 100
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   output logic done_o
);
   initial begin
      if (CYCLES < 1 || CYCLES > 65535) begin
         $error("timer count out of range");
      end
   end
   logic [15:0] count; // cycles still to run
   logic running; // counting

   ////////////////////////////////////////////////////////////////////////
   // countdown
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= 16'h0000;
         running <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            count <= 16'(CYCLES);
            running <= 1'b1;
         end else if (running) begin
            if (count == 16'h0001) begin
               running <= 1'b0;
               done_o <= 1'b1;
            end
            count <= count - 16'h0001;
         end
      end
   end
endmodule : fac_timer

// >>> pkg/fac_params.svh
// Purpose: constants of the flash access and unlock control block
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: definitions only
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH

// geometry
`define FAC_MAIN_BASE 32'h0800_0000
`define FAC_MAIN_BYTES 32'h0001_0000
`define FAC_INFO_BASE 32'h1FFF_0000
`define FAC_INFO_BYTES 32'h0000_1000
`define FAC_PAGE_SHIFT 7
`define FAC_SECTOR_SHIFT 12
`define FAC_LOADER_LAST_PAGE 5'h1B
`define FAC_ID_PAGE 5'h1C
`define FAC_OPTION_PAGE 5'h1D
`define FAC_FACTORY_PAGE 5'h1E
// register byte offsets inside the register window
`define FAC_REG_BASE 32'h4002_2000
`define FAC_REG_MASK 32'hFFFF_FFE0
`define FAC_OFS_ACR 5'h00
`define FAC_OFS_KEY 5'h08
`define FAC_OFS_SR 5'h10
`define FAC_OFS_CR 5'h14
`define FAC_OFS_WRP 5'h18
// unlock values
`define FAC_FIRST_UNLOCK_VALUE 32'h4567_0123
`define FAC_SECOND_UNLOCK_VALUE 32'hCDEF_89AB
// control register field positions
`define FAC_CR_PG 0
`define FAC_CR_PER 1
`define FAC_CR_MER 2
`define FAC_CR_SER 3
`define FAC_CR_RELOAD 27
`define FAC_CR_LOCK 31
// status fields
`define FAC_SR_EOP 0
`define FAC_SR_WRPERR 4
`define FAC_SR_BUSY 16
// reset values
`define FAC_CR_RESET 32'h8000_0000
`define FAC_ACR_RESET 32'h0000_0000
// operation length
`define FAC_OP_NS 1000
`define FAC_CLK_NS 10

`endif

// >>> pkg/fac_pkg.sv
// Purpose: types of the flash access and unlock control block
// Assumes: nothing
// Notes: constants live in fac_params.svh
package fac_pkg;
   // unlock sequencer state
   typedef enum logic [1:0] {
      FAC_LOCKED = 2'b00,
      FAC_HALF   = 2'b01,
      FAC_OPEN   = 2'b10,
      FAC_DEAD   = 2'b11
   } fac_key_t;
   // operation kind
   typedef enum logic [2:0] {
      FAC_OP_NONE   = 3'b000,
      FAC_OP_PROG   = 3'b001,
      FAC_OP_PAGE   = 3'b010,
      FAC_OP_SECTOR = 3'b011,
      FAC_OP_MASS   = 3'b100
   } fac_op_t;
endpackage : fac_pkg
